// ==== design/ssc_consts.svh ====
// Purpose: Constants of the sensor supply current-limit controller
// Assumes: 10 MHz core clock
// Notes: Times are kept in microseconds, cycle counts derive from them
`ifndef SSC_CONSTS_SVH
`define SSC_CONSTS_SVH

// ----------------------------------------
// Register offsets and reset values
// ----------------------------------------
`define SSC_CFG_OFS 8'h18
`define SSC_STAT_OFS 8'hF0
`define SSC_CFG_RST 8'h00
`define SSC_UNMAPPED_RD 8'h00

// ----------------------------------------
// Configuration field positions
// ----------------------------------------
`define SSC_EN_BIT 0
`define SSC_LIMDIS_BIT 1
`define SSC_DBL_BIT 2
`define SSC_BLANK_LSB 3
`define SSC_BLANK_MSB 4
`define SSC_DYN_BIT 5
`define SSC_RETRY_LSB 6
`define SSC_RETRY_MSB 7

// ----------------------------------------
// Timing
// ----------------------------------------
`define SSC_CLK_MHZ 10
`define SSC_EN_FILT_US 200
`define SSC_BLANK0_US 5500
`define SSC_BLANK1_US 16500
`define SSC_BLANK2_US 55000
`define SSC_BLANK3_US 165000
`define SSC_RETRY1_US 400000
`define SSC_RETRY2_US 4000000
`define SSC_RETRY3_US 12000000

`endif

// ==== design/ssc_pkg.sv ====
// Purpose: Types of the sensor supply current-limit controller
// Assumes: Nothing beyond the constants header
// Notes: Timer width covers the longest retry period
`default_nettype none

package ssc_pkg;

	// Supply controller states
	typedef enum logic [2:0] {
		ST_OFF = 3'b000,
		ST_ON = 3'b001,
		ST_BLANK = 3'b010,
		ST_RETRY = 3'b011,
		ST_LATCH = 3'b100
	} ssc_state_t;

	// Wide enough for 12 s at 10 MHz
	typedef logic [26:0] ssc_cnt_t;

endpackage : ssc_pkg

`default_nettype wire

// ==== design/ssc_en_if.sv ====
// Purpose: Carries the supply enable between register and filter
// Assumes: Single clock domain
// Notes: raw is the register bit, filt the accepted level
`default_nettype none

interface ssc_en_if;
	logic raw;
	logic filt;
	modport filter_mp (input raw, output filt);
	modport user_mp (output raw, input filt);
endinterface : ssc_en_if

`default_nettype wire

// ==== design/ssc_en_filter.sv ====
// Purpose: Rejects short pulses on the supply enable bit
// Assumes: raw is synchronous to core_clk
// Notes: A change must hold for the full filter time to pass
`include "ssc_consts.svh"
`default_nettype none

module ssc_en_filter (
	input wire logic core_clk, // Core clock
	input wire logic resetn, // Sync reset, active low
	ssc_en_if.filter_mp en_io // Raw in, filtered out
);
	localparam logic [11:0] FILT_CYC = 12'(`SSC_EN_FILT_US * `SSC_CLK_MHZ);

	logic [11:0] run_q;
	logic [11:0] run_d;
	logic filt_q;
	logic filt_d;

	// Count how long raw has differed from the accepted level
	always_comb
	begin
		run_d = 12'h000;
		filt_d = filt_q;
		if (en_io.raw != filt_q)
		begin
			if (run_q == FILT_CYC - 12'h001)
			begin
				filt_d = en_io.raw;
			end
			else
			begin
				run_d = run_q + 12'h001;
			end
		end
	end

	// Registers; a glitch back restarts the count from zero
	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			run_q <= 12'h000;
			filt_q <= 1'b0;
		end
		else
		begin
			run_q <= run_d;
			filt_q <= filt_d;
		end
	end

	assign en_io.filt = filt_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_filt_hold;
		@(posedge core_clk) disable iff (!resetn)
		$changed(filt_q) |-> $past(run_q) == FILT_CYC - 12'h001;
	endproperty
	a_filt_hold: assert property (p_filt_hold) else $error("enable passed before filter time");

endmodule : ssc_en_filter

`default_nettype wire

// ==== design/ssc_supply_ctrl.sv ====
// Purpose: Current-limit and retry control for one sensor supply switch
// Assumes: Comparator and register inputs synchronous to core_clk
// Notes: Long counts are parameters so simulation can shorten them
//
// Contract
// - Retry field: latch-off or 400ms/4s/12s retry
// - Blanking field selects 5.5/16.5/55/165 ms
// - Dynamic blanking shortens time below 18 V
// - Between 9 and 17 V: half blanking time
// - Below 9 V: quarter blanking time
// - Double limit during blanking above 18 V
// - Limit disable: no limiting, sense amp off
// - Enable bit turns on pass gate drive
// - Enable cleared resets all limit timers
// - Enable pulses under 200 us ignored
`include "ssc_consts.svh"
`default_nettype none

module ssc_supply_ctrl #(
	parameter ssc_pkg::ssc_cnt_t BLANK0_CYC = 27'(`SSC_BLANK0_US * `SSC_CLK_MHZ),
	parameter ssc_pkg::ssc_cnt_t BLANK1_CYC = 27'(`SSC_BLANK1_US * `SSC_CLK_MHZ),
	parameter ssc_pkg::ssc_cnt_t BLANK2_CYC = 27'(`SSC_BLANK2_US * `SSC_CLK_MHZ),
	parameter ssc_pkg::ssc_cnt_t BLANK3_CYC = 27'(`SSC_BLANK3_US * `SSC_CLK_MHZ),
	parameter ssc_pkg::ssc_cnt_t RETRY1_CYC = 27'(`SSC_RETRY1_US * `SSC_CLK_MHZ),
	parameter ssc_pkg::ssc_cnt_t RETRY2_CYC = 27'(`SSC_RETRY2_US * `SSC_CLK_MHZ),
	parameter ssc_pkg::ssc_cnt_t RETRY3_CYC = 27'(`SSC_RETRY3_US * `SSC_CLK_MHZ)
) (
	input wire logic core_clk, // Core clock, 10 MHz
	input wire logic resetn, // Sync reset, active low
	input wire logic [7:0] reg_addr, // Register address
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	input wire logic [7:0] reg_wdata, // Write data
	output logic [7:0] reg_rdata, // Read data, one cycle after strobe
	input wire logic oc_normal, // Current above normal threshold
	input wire logic oc_double, // Current above double threshold
	input wire logic out_below_18v, // Supply output below 18 V
	input wire logic out_below_9v, // Supply output below 9 V
	output logic pass_gate_drive, // Gate driver of pass transistor
	output logic sense_amp_en, // Current-sense amplifier on
	output logic dbl_thresh_sel, // Analog limit set to double
	output ssc_pkg::ssc_state_t ctrl_state // Controller state
);
	import ssc_pkg::*;

	// ----------------------------------------
	// Decoding helpers
	// ----------------------------------------
	function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] ofs);
		addr_hit = (addr == ofs);
	endfunction : addr_hit

	// Blanking advance per cycle; larger steps shorten the window
	function automatic ssc_cnt_t blank_step(input logic dyn, input logic b18, input logic b9);
		blank_step = 27'h0000001;
		if (dyn && b9)
		begin
			blank_step = 27'h0000004;
		end
		else if (dyn && b18)
		begin
			blank_step = 27'h0000002;
		end
	endfunction : blank_step

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic [7:0] cfg_q;
	logic [7:0] cfg_d;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	ssc_state_t state_q;
	ssc_state_t state_d;
	ssc_cnt_t tmr_q;
	ssc_cnt_t tmr_d;
	logic gate_q;
	logic gate_d;
	logic [1:0] retry_sel;
	logic [1:0] blank_sel;
	logic dyn_en;
	logic dbl_en;
	logic lim_dis;
	logic en_ok;
	logic oc_now;
	ssc_cnt_t blank_lim;
	ssc_cnt_t retry_lim;
	ssc_en_if en_bus ();

	// ----------------------------------------
	// Configuration fields
	// ----------------------------------------
	assign retry_sel = cfg_q[`SSC_RETRY_MSB:`SSC_RETRY_LSB];
	assign blank_sel = cfg_q[`SSC_BLANK_MSB:`SSC_BLANK_LSB];
	assign dyn_en = cfg_q[`SSC_DYN_BIT];
	assign dbl_en = cfg_q[`SSC_DBL_BIT];
	assign lim_dis = cfg_q[`SSC_LIMDIS_BIT];
	assign en_bus.raw = cfg_q[`SSC_EN_BIT];
	assign en_ok = en_bus.filt;

	// Enable filter keeps short writes from toggling the gate
	ssc_en_filter u_en_filter (
		.core_clk(core_clk),
		.resetn(resetn),
		.en_io(en_bus.filter_mp)
	);

	// Blanking and retry limits from the fields
	always_comb
	begin
		case (blank_sel)
			2'b00: blank_lim = BLANK0_CYC;
			2'b01: blank_lim = BLANK1_CYC;
			2'b10: blank_lim = BLANK2_CYC;
			default: blank_lim = BLANK3_CYC;
		endcase
		case (retry_sel)
			2'b01: retry_lim = RETRY1_CYC;
			2'b10: retry_lim = RETRY2_CYC;
			default: retry_lim = RETRY3_CYC;
		endcase
	end

	// Threshold choice; double only in blanking with output high
	assign dbl_thresh_sel = dbl_en && !lim_dis && state_q == ST_BLANK && !out_below_18v;
	assign oc_now = !lim_dis && (dbl_thresh_sel ? oc_double : oc_normal);
	assign sense_amp_en = !lim_dis;

	// ----------------------------------------
	// Register access
	// ----------------------------------------
	always_comb
	begin
		cfg_d = cfg_q;
		rdata_d = rdata_q;
		if (reg_wr && addr_hit(reg_addr, `SSC_CFG_OFS))
		begin
			cfg_d = reg_wdata;
		end
		if (reg_rd)
		begin
			if (addr_hit(reg_addr, `SSC_CFG_OFS))
			begin
				rdata_d = cfg_q;
			end
			else if (addr_hit(reg_addr, `SSC_STAT_OFS))
			begin
				rdata_d = {3'h0, dbl_thresh_sel, gate_q, state_q};
			end
			else
			begin
				rdata_d = `SSC_UNMAPPED_RD;
			end
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			cfg_q <= `SSC_CFG_RST;
			rdata_q <= 8'h00;
		end
		else
		begin
			cfg_q <= cfg_d;
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;

	// ----------------------------------------
	// Limit state machine
	// ----------------------------------------
	// One timer serves blanking and retry; they never overlap
	always_comb
	begin
		state_d = state_q;
		tmr_d = tmr_q;
		case (state_q)
			ST_OFF:
			begin
				tmr_d = 27'h0000000;
				if (en_ok)
				begin
					state_d = ST_ON;
				end
			end
			ST_ON:
			begin
				tmr_d = 27'h0000000;
				if (oc_now)
				begin
					state_d = ST_BLANK;
				end
			end
			ST_BLANK:
			begin
				if (!oc_now)
				begin
					state_d = ST_ON;
					tmr_d = 27'h0000000;
				end
				else if (tmr_q + blank_step(dyn_en, out_below_18v, out_below_9v) >= blank_lim)
				begin
					state_d = (retry_sel == 2'b00) ? ST_LATCH : ST_RETRY;
					tmr_d = 27'h0000000;
				end
				else
				begin
					tmr_d = tmr_q + blank_step(dyn_en, out_below_18v, out_below_9v);
				end
			end
			ST_RETRY:
			begin
				if (tmr_q >= retry_lim - 27'h0000001)
				begin
					state_d = ST_ON;
					tmr_d = 27'h0000000;
				end
				else
				begin
					tmr_d = tmr_q + 27'h0000001;
				end
			end
			ST_LATCH:
			begin
				tmr_d = 27'h0000000;
			end
			default:
			begin
				state_d = ST_OFF;
				tmr_d = 27'h0000000;
			end
		endcase
		// Disable wins over everything and clears the timers
		if (!en_ok)
		begin
			state_d = ST_OFF;
			tmr_d = 27'h0000000;
		end
		gate_d = (state_d == ST_ON) || (state_d == ST_BLANK);
	end

	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			state_q <= ST_OFF;
			tmr_q <= 27'h0000000;
			gate_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			tmr_q <= tmr_d;
			gate_q <= gate_d;
		end
	end

	assign pass_gate_drive = gate_q;
	assign ctrl_state = state_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);

	property p_en_off;
		$fell(en_ok) |=> !pass_gate_drive && tmr_q == 27'h0000000 && state_q == ST_OFF;
	endproperty
	a_en_off: assert property (p_en_off) else $error("enable low did not stop supply");

	property p_gate_on;
		(state_q == ST_OFF && en_ok) |=> pass_gate_drive && state_q == ST_ON;
	endproperty
	a_gate_on: assert property (p_gate_on) else $error("gate not driven after enable");

	property p_latch_only_00;
		(state_q == ST_BLANK && state_d == ST_LATCH) |-> retry_sel == 2'b00;
	endproperty
	a_latch_only_00: assert property (p_latch_only_00) else $error("latch-off with retry selected");

	property p_latch_holds;
		(state_q == ST_LATCH && en_ok) |=> state_q == ST_LATCH && !pass_gate_drive;
	endproperty
	a_latch_holds: assert property (p_latch_holds) else $error("latch-off left without enable cycle");

	property p_no_limit;
		lim_dis |-> (!sense_amp_en && !oc_now) ##1 (state_q != ST_BLANK || !lim_dis);
	endproperty
	a_no_limit: assert property (p_no_limit) else $error("limiting active while disabled");

	property p_dbl_sel;
		(state_q == ST_BLANK && en_ok && dbl_en && !lim_dis && !out_below_18v && !oc_double) |=> state_q == ST_ON;
	endproperty
	a_dbl_sel: assert property (p_dbl_sel) else $error("double limit not applied in blanking");

	property p_quarter;
		(state_q == ST_BLANK && state_d == ST_BLANK && en_ok && dyn_en && out_below_9v)
		|=> tmr_q == $past(tmr_q) + 27'h0000004;
	endproperty
	a_quarter: assert property (p_quarter) else $error("quarter blanking step wrong");

	property p_half;
		(state_q == ST_BLANK && state_d == ST_BLANK && en_ok && dyn_en && out_below_18v && !out_below_9v)
		|=> tmr_q == $past(tmr_q) + 27'h0000002;
	endproperty
	a_half: assert property (p_half) else $error("half blanking step wrong");

	property p_full;
		(state_q == ST_BLANK && state_d == ST_BLANK && en_ok && !dyn_en)
		|=> tmr_q == $past(tmr_q) + 27'h0000001;
	endproperty
	a_full: assert property (p_full) else $error("full blanking step wrong");

	property p_blank_end;
		(state_q == ST_BLANK && en_ok && oc_now && state_d != ST_BLANK)
		|-> tmr_q + blank_step(dyn_en, out_below_18v, out_below_9v) >= blank_lim ##1 !pass_gate_drive;
	endproperty
	a_blank_end: assert property (p_blank_end) else $error("blanking ended early or gate stayed on");

	property p_recover;
		(state_q == ST_BLANK && !oc_now && en_ok) |=> state_q == ST_ON && pass_gate_drive;
	endproperty
	a_recover: assert property (p_recover) else $error("no return to on after overcurrent cleared");

	c_latch: cover property (state_q == ST_BLANK ##1 state_q == ST_LATCH);
	c_retry: cover property (state_q == ST_RETRY ##1 state_q == ST_ON);
	c_recover: cover property (state_q == ST_BLANK ##1 state_q == ST_ON);

endmodule : ssc_supply_ctrl

`default_nettype wire

// ==== verif/ssc_ext_pass_model.sv ====
// Purpose: Pass transistor, sense resistor and comparators seen by the controller
// Assumes: Bench picks the load fault level and the output voltage band
// Notes: Comparators answer at once; no current flows with the gate off
`default_nettype none

module ssc_ext_pass_model (
	input wire logic pass_gate_drive, // Gate from controller
	input wire logic sense_amp_en, // Sense amp power
	input wire logic [1:0] fault_lvl, // 0 none, 1 over normal, 2 over double
	input wire logic [1:0] volt_band, // 0 high, 1 9..17 V, 2 under 9 V
	output logic oc_normal, // Over normal limit
	output logic oc_double, // Over double limit
	output logic out_below_18v, // Output under 18 V
	output logic out_below_9v // Output under 9 V
);
	timeunit 1ns;
	timeprecision 1ns;

	// ----
	// Comparators
	// ----
	// Gate off leaves the output at 0 V, so no current and low voltage
	always_comb
	begin
		oc_normal = pass_gate_drive && sense_amp_en && fault_lvl != 2'h0;
		oc_double = pass_gate_drive && sense_amp_en && fault_lvl == 2'h2;
		out_below_18v = !pass_gate_drive || volt_band != 2'h0;
		out_below_9v = !pass_gate_drive || volt_band == 2'h2;
	end
endmodule : ssc_ext_pass_model

`default_nettype wire

// ==== verif/ssc_supply_ctrl_test.sv ====
// Purpose: Self-checking bench of the supply current-limit controller
// Assumes: Shortened blanking and retry counts, enable filter at full length
// Notes: Outputs are sampled on the falling edge, inputs move on the rising edge
`default_nettype none

module ssc_supply_ctrl_test;
	timeunit 1ns;
	timeprecision 1ns;
	import ssc_pkg::*;

	// ----
	// Signals and short counts
	// ----
	localparam int BL[4] = '{8, 16, 32, 4000};
	localparam int RT[4] = '{0, 100, 200, 300};
	typedef struct {logic [7:0] cfg; logic [1:0] volt; logic [1:0] lvl; logic dbl; ssc_state_t nxt;} ssc_row_t;
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic oc_normal, oc_double, out_below_18v, out_below_9v;
	logic pass_gate_drive, sense_amp_en, dbl_thresh_sel;
	ssc_state_t ctrl_state;
	logic [1:0] fault_lvl = 2'h0;
	logic [1:0] volt_band = 2'h0;
	int error_cnt = 0;
	int samples_checked = 0;
	// Retry codes 01..11, every blank code, both voltage reductions, double limit
	ssc_row_t rows[9] = '{'{8'h41, 2'h0, 2'h2, 1'b0, ST_RETRY}, '{8'h89, 2'h1, 2'h2, 1'b0, ST_RETRY},
		'{8'hF1, 2'h1, 2'h2, 1'b0, ST_RETRY}, '{8'h69, 2'h2, 2'h2, 1'b0, ST_RETRY},
		'{8'h61, 2'h0, 2'h2, 1'b0, ST_RETRY}, '{8'h8D, 2'h0, 2'h2, 1'b1, ST_RETRY},
		'{8'h45, 2'h1, 2'h2, 1'b0, ST_RETRY}, '{8'h4D, 2'h0, 2'h1, 1'b1, ST_ON},
		'{8'h59, 2'h0, 2'h2, 1'b0, ST_RETRY}};

	always #50 core_clk = ~core_clk;

	ssc_supply_ctrl #(.BLANK0_CYC(ssc_cnt_t'(BL[0])), .BLANK1_CYC(ssc_cnt_t'(BL[1])),
		.BLANK2_CYC(ssc_cnt_t'(BL[2])), .BLANK3_CYC(ssc_cnt_t'(BL[3])), .RETRY1_CYC(ssc_cnt_t'(RT[1])),
		.RETRY2_CYC(ssc_cnt_t'(RT[2])), .RETRY3_CYC(ssc_cnt_t'(RT[3]))) ssc_supply_ctrl_i (
		.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .oc_normal(oc_normal), .oc_double(oc_double),
		.out_below_18v(out_below_18v), .out_below_9v(out_below_9v), .pass_gate_drive(pass_gate_drive),
		.sense_amp_en(sense_amp_en), .dbl_thresh_sel(dbl_thresh_sel), .ctrl_state(ctrl_state));

	ssc_ext_pass_model ssc_ext_pass_model_i (.pass_gate_drive(pass_gate_drive), .sense_amp_en(sense_amp_en),
		.fault_lvl(fault_lvl), .volt_band(volt_band), .oc_normal(oc_normal), .oc_double(oc_double),
		.out_below_18v(out_below_18v), .out_below_9v(out_below_9v));

	// ----
	// Tasks
	// ----
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check

	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : wrap_up

	// Strobe held for exactly one sampling edge
	task automatic reg_wr8(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : reg_wr8

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(negedge core_clk);
		check(reg_rdata, exp);
	endtask : rd_chk

	// Bounded wait; a miss shows up in the following comparison
	task automatic wait_st(input ssc_state_t st, input int lim, output int n);
		n = 0;
		do
		begin
			@(negedge core_clk);
			n++;
		end
		while (ctrl_state !== st && n < lim);
	endtask : wait_st

	// Cycles spent in one state, plus the threshold select on entry
	task automatic count_run(input ssc_state_t st, output int n, output logic d);
		wait_st(st, 5000, n);
		d = dbl_thresh_sel;
		n = 0;
		while (ctrl_state === st && n < 9000)
		begin
			@(negedge core_clk);
			n++;
		end
	endtask : count_run

	task automatic done(input string s);
		$display("test %s done", s);
	endtask : done

	function automatic int exp_blank(input logic [7:0] c, input logic [1:0] v);
		return !c[5] || v == 2'h0 ? BL[c[4:3]] : (v == 2'h1 ? BL[c[4:3]] / 2 : BL[c[4:3]] / 4);
	endfunction : exp_blank

	// ----
	// Sequence
	// ----
	initial
	begin
		#(60000 * 100);
		error_cnt++;
		$display("ERROR at %0t: watchdog expired", $time);
		wrap_up();
	end

	initial
	begin
		int n;
		int k;
		logic d;
		repeat (10) @(posedge core_clk);
		resetn <= 1'b1;
		@(negedge core_clk);
		check({ctrl_state, pass_gate_drive, sense_amp_en, dbl_thresh_sel}, 32'h02);
		rd_chk(8'h18, 8'h00);
		rd_chk(8'h20, 8'h00);
		reg_wr8(8'h19, 8'hFF);
		rd_chk(8'h18, 8'h00);
		done("registers");
		// Enable pulse just under the filter time must not reach the gate
		k = 0;
		reg_wr8(8'h18, 8'h01);
		repeat (1990) @(negedge core_clk) k += (pass_gate_drive !== 1'b0);
		reg_wr8(8'h18, 8'h00);
		repeat (2100) @(negedge core_clk) k += (pass_gate_drive !== 1'b0);
		check(k, 0);
		reg_wr8(8'h18, 8'h01);
		wait_st(ST_ON, 2100, n);
		check(n >= 1999 && n <= 2003, 1);
		check(pass_gate_drive, 1'b1);
		rd_chk(8'hF0, 8'h09);
		rd_chk(8'h18, 8'h01);
		done("enable");
		foreach (rows[i])
		begin
			@(posedge core_clk);
			fault_lvl <= 2'h0;
			volt_band <= rows[i].volt;
			reg_wr8(8'h18, rows[i].cfg);
			repeat (3) @(negedge core_clk);
			check(ctrl_state, ST_ON);
			@(posedge core_clk);
			fault_lvl <= rows[i].lvl;
			count_run(ST_BLANK, n, d);
			check(n, rows[i].nxt == ST_ON ? 1 : exp_blank(rows[i].cfg, rows[i].volt));
			check(d, rows[i].dbl);
			check(ctrl_state, rows[i].nxt);
			if (rows[i].nxt == ST_RETRY)
			begin
				check(pass_gate_drive, 1'b0);
				// Already at the first retry cycle, so count from here
				n = 0;
				while (ctrl_state === ST_RETRY && n < 9000)
				begin
					@(negedge core_clk);
					n++;
				end
				check(n, RT[rows[i].cfg[7:6]]);
				check({ctrl_state, pass_gate_drive}, {ST_ON, 1'b1});
			end
			done("row");
		end
		// Latch-off: no retry, host restarts by cycling the enable
		@(posedge core_clk);
		fault_lvl <= 2'h0;
		reg_wr8(8'h18, 8'h01);
		@(posedge core_clk);
		fault_lvl <= 2'h2;
		count_run(ST_BLANK, n, d);
		repeat (400) @(negedge core_clk);
		check({ctrl_state, pass_gate_drive}, {ST_LATCH, 1'b0});
		reg_wr8(8'h18, 8'h00);
		wait_st(ST_OFF, 2100, n);
		check(ctrl_state, ST_OFF);
		reg_wr8(8'h18, 8'h19);
		count_run(ST_BLANK, n, d);
		reg_wr8(8'h18, 8'h18);
		wait_st(ST_OFF, 2100, n);
		reg_wr8(8'h18, 8'h19);
		count_run(ST_BLANK, n, d);
		check(n, BL[3]);
		done("latch");
		// Partial blanking cut by enable low, then a full blanking time again
		reg_wr8(8'h18, 8'h18);
		wait_st(ST_OFF, 2100, n);
		reg_wr8(8'h18, 8'h19);
		wait_st(ST_BLANK, 5000, n);
		repeat (1000) @(negedge core_clk);
		reg_wr8(8'h18, 8'h18);
		repeat (1990) @(negedge core_clk);
		check(ctrl_state, ST_BLANK);
		wait_st(ST_OFF, 2100, n);
		check(ctrl_state, ST_OFF);
		reg_wr8(8'h18, 8'h19);
		count_run(ST_BLANK, n, d);
		check(n, BL[3]);
		@(posedge core_clk);
		fault_lvl <= 2'h0;
		reg_wr8(8'h18, 8'h00);
		wait_st(ST_OFF, 2100, n);
		reg_wr8(8'h18, 8'h03);
		wait_st(ST_ON, 2100, n);
		@(posedge core_clk);
		fault_lvl <= 2'h2;
		repeat (50) @(negedge core_clk);
		check({ctrl_state, pass_gate_drive, sense_amp_en}, {ST_ON, 2'b10});
		done("limit_disable");
		// Reset in mid-run returns the register and every output to idle
		@(posedge core_clk);
		resetn <= 1'b0;
		repeat (3) @(posedge core_clk);
		resetn <= 1'b1;
		repeat (2) @(negedge core_clk);
		check({ctrl_state, pass_gate_drive, sense_amp_en, dbl_thresh_sel}, 32'h02);
		rd_chk(8'h18, 8'h00);
		done("reset");
		wrap_up();
	end
endmodule : ssc_supply_ctrl_test

`default_nettype wire
